// ===== tb/input_select_props.sv
// Checker on the selector top ports: bus answer, read-back and routing.
// Assumes the zero-wait APB slave and the package register map.
`timescale 1ns/1ps
`default_nettype none
module input_select_props
  import input_select_pkg::*;
(
  // Clock and bus
  input wire logic                CLK,
  input wire logic                RST_N,
  input wire logic                CE,
  input wire logic                PSEL,
  input wire logic                PENABLE,
  input wire logic                PWRITE,
  input wire logic [ADDR_W-1:0]   PADDR,
  input wire logic                PREADY,
  input wire logic                PSLVERR,
  input wire logic [DATA_W-1:0]   PRDATA,
  // Pins and routed inputs
  input wire logic [NUM_PINS-1:0] ANALOG_SEL,
  input wire logic [NUM_PINS-1:0] REMAPPABLE_PIN,
  input wire logic                TIMER5_EXT_CLOCK,
  input wire logic                CAPTURE_CH1,
  input wire logic                SERIAL1_CLEAR_TO_SEND
);
  logic acc;
  logic bad;
  logic any;
  assign acc = PSEL && PENABLE;
  assign bad = (PADDR > OFS_SERIAL1) || (PADDR[1:0] != 2'h0);
  assign any = TIMER5_EXT_CLOCK || CAPTURE_CH1 || SERIAL1_CLEAR_TO_SEND;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_ready_zero_wait: assert property (PREADY == acc)
    else $error("pready off access");
  a_slave_error: assert property (acc |-> PSLVERR == bad)
    else $error("pslverr wrong");
  a_reserved_zero: assert property (acc && !PWRITE |-> PRDATA[31:14] == '0 && PRDATA[7:6] == '0)
    else $error("reserved bits set");
  a_low_half_absent: assert property (acc && !PWRITE && $past(CE) &&
    (PADDR == OFS_CAPTURE9 || PADDR == OFS_SERIAL3) |-> PRDATA[7:0] == '0) else $error("low half live");
  a_unmapped_zero: assert property (acc && !PWRITE && bad && $past(CE) |-> PRDATA == '0)
    else $error("unmapped read data");
  a_reset_inactive: assert property (!$past(RST_N) |-> PRDATA == '0 && !any)
    else $error("reset state wrong");
  a_analog_blocks: assert property ((CE && &ANALOG_SEL) [*2] |-> !any)
    else $error("analog pin routed");
  a_freeze_ce: assert property (!CE |=> $stable(PRDATA) && $stable(CAPTURE_CH1))
    else $error("state moved with ce low");
  a_pins_idle: assert property ((CE && REMAPPABLE_PIN == '0) [*4] |-> !any)
    else $error("output high with pins low");
  c_error: cover property (acc && PSLVERR);
  c_cap9: cover property (acc && !PWRITE && PADDR == OFS_CAPTURE9);
  c_route: cover property (CAPTURE_CH1 && !$past(CE));
endmodule : input_select_props
`default_nettype wire

// ===== tb/tb_remappable_input_select.sv
// Self-checking bench for the remappable input selector.
// Assumes a 40 ns clock and the zero-wait APB slave.
`timescale 1ns/1ps
`default_nettype none
module tb_remappable_input_select
  import input_select_pkg::*;
;
  logic CLK = 1'b0, RST_N = 1'b0, CE = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, ROUTING_LOCK = 1'b0;
  logic [ADDR_W-1:0]   PADDR = '0;
  logic [DATA_W-1:0]   PWDATA = '0;
  logic [STRB_W-1:0]   PSTRB = '0;
  logic [NUM_PINS-1:0] ANALOG_SEL = '0, REMAPPABLE_PIN = '0;
  wire                 PREADY, PSLVERR;
  wire  [DATA_W-1:0]   PRDATA;
  wire  [17:0]         outs;
  sel_t                mir [18];
  int                  num_errors = 0, comparisons = 0;

  always #20 CLK = ~CLK;
  assign outs[12] = 1'b0;
  assign outs[14] = 1'b0;

  remappable_input_select i_dut (.CLK(CLK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PRDATA(PRDATA), .ROUTING_LOCK(ROUTING_LOCK), .ANALOG_SEL(ANALOG_SEL), .REMAPPABLE_PIN(REMAPPABLE_PIN),
    .TIMER4_EXT_CLOCK(outs[0]), .TIMER5_EXT_CLOCK(outs[1]), .CAPTURE_CH1(outs[2]), .CAPTURE_CH2(outs[3]),
    .CAPTURE_CH3(outs[4]), .CAPTURE_CH4(outs[5]), .CAPTURE_CH5(outs[6]), .CAPTURE_CH6(outs[7]),
    .CAPTURE_CH7(outs[8]), .CAPTURE_CH8(outs[9]), .COMPARE_FAULT_A(outs[10]), .COMPARE_FAULT_B(outs[11]),
    .CAPTURE_CH9(outs[13]), .SERIAL3_RECEIVE(outs[15]), .SERIAL1_RECEIVE(outs[16]),
    .SERIAL1_CLEAR_TO_SEND(outs[17]));

  function automatic logic [31:0] exp_rd(input int r);
    if (r >= NUM_REGS)
      return 32'h0000_0000;
    return {18'h0, mir[2 * r + 1], 2'h0, IMPL_LO[r] ? mir[2 * r] : 6'h00};
  endfunction : exp_rd

  function automatic logic exp_out(input int k);
    return (mir[k] < NUM_PINS) && REMAPPABLE_PIN[mir[k]] && !ANALOG_SEL[mir[k]];
  endfunction : exp_out

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input int r, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rd);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= ADDR_W'(r * 4);
    PWDATA <= d;
    PSTRB <= s;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    rd = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic verify();
    logic [31:0] rd;
    for (int k = 0; k < 18; k++)
      check(32'(outs[k]), 32'(exp_out(k)));
    for (int r = 0; r < NUM_REGS + 2; r++)
    begin
      apb(1'b0, (r < NUM_REGS) ? r : 246 + r, 32'h0000_0000, 4'h0, rd);
      check(rd, exp_rd(r));
    end
  endtask : verify

  task automatic results();
    if (num_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  initial
  begin
    logic [31:0] d;
    logic [31:0] rd;
    logic [3:0]  s;
    void'($urandom(27));
    foreach (mir[k]) mir[k] = SEL_RESET;
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    for (int i = 0; i < 20; i++)
    begin
      verify();
      ROUTING_LOCK <= (i == 2) || ($urandom_range(3, 0) == 0);
      ANALOG_SEL <= (i == 0) ? '1 : NUM_PINS'({$urandom, $urandom} & {$urandom, $urandom});
      REMAPPABLE_PIN <= (i == 1) ? '0 : (i < 6) ? '1 : NUM_PINS'({$urandom, $urandom});
      s = (i < 6) ? 4'hF : 4'($urandom);
      for (int r = 0; r < NUM_REGS; r++)
      begin
        d = (i == 4) ? 32'h0000_2E2E : (i == 5) ? 32'h0000_2F2F : $urandom;
        apb(1'b1, r, d, s, rd);
        if (!ROUTING_LOCK)
        begin
          if (s[0] && IMPL_LO[r]) mir[2 * r] = d[5:0];
          if (s[1]) mir[2 * r + 1] = d[13:8];
        end
      end
      CE <= 1'b0;
      repeat (3) @(posedge CLK);
      CE <= 1'b1;
      repeat (5) @(posedge CLK);
    end
    verify();
    results();
  end

  initial
  begin
    repeat (5000) @(posedge CLK);
    num_errors++;
    results();
  end
endmodule : tb_remappable_input_select

bind remappable_input_select input_select_props i_props (.CLK(CLK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
  .ANALOG_SEL(ANALOG_SEL), .REMAPPABLE_PIN(REMAPPABLE_PIN), .TIMER5_EXT_CLOCK(TIMER5_EXT_CLOCK),
  .CAPTURE_CH1(CAPTURE_CH1), .SERIAL1_CLEAR_TO_SEND(SERIAL1_CLEAR_TO_SEND));
`default_nettype wire

// ===== verilog/input_select_pkg.sv
// Constants, field layout and state type of the remappable input selector.
// Assumes a 32-bit APB bus with aligned word registers.
`default_nettype none

package input_select_pkg;

  // Bus geometry
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 32;
  localparam int STRB_W   = DATA_W / 8;
  localparam int IDX_LSB  = 2;
  localparam int IDX_W    = 4;

  // Pin space: remappable and input-only pins numbered 0 .. NUM_PINS-1
  localparam int NUM_PINS = 47;

  // Selector field layout
  localparam int SEL_W    = 6;
  localparam int HI_LSB   = 8;
  localparam int LO_LSB   = 0;
  localparam int HALF_LO  = 0;
  localparam int HALF_HI  = 1;
  localparam int LANE_LO  = 0;
  localparam int LANE_HI  = 1;
  localparam logic [SEL_W-1:0] SEL_RESET = 6'h3F;

  // Register indices
  localparam int NUM_REGS = 9;
  localparam logic [IDX_W-1:0] IDX_TIMER45   = 4'h0;
  localparam logic [IDX_W-1:0] IDX_CAPTURE12 = 4'h1;
  localparam logic [IDX_W-1:0] IDX_CAPTURE34 = 4'h2;
  localparam logic [IDX_W-1:0] IDX_CAPTURE56 = 4'h3;
  localparam logic [IDX_W-1:0] IDX_CAPTURE78 = 4'h4;
  localparam logic [IDX_W-1:0] IDX_FAULT     = 4'h5;
  localparam logic [IDX_W-1:0] IDX_CAPTURE9  = 4'h6;
  localparam logic [IDX_W-1:0] IDX_SERIAL3   = 4'h7;
  localparam logic [IDX_W-1:0] IDX_SERIAL1   = 4'h8;

  // Byte offsets on the bus
  localparam logic [ADDR_W-1:0] OFS_TIMER45   = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE12 = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE34 = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE56 = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE78 = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_FAULT     = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE9  = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_SERIAL3   = 12'h01C;
  localparam logic [ADDR_W-1:0] OFS_SERIAL1   = 12'h020;

  // Which halves hold a field; capture 9 and serial 3 have no low field
  localparam logic [NUM_REGS-1:0] IMPL_HI = 9'h1FF;
  localparam logic [NUM_REGS-1:0] IMPL_LO = 9'h13F;

  // Level a peripheral input sees when routed to nothing
  localparam logic INACTIVE_LEVEL = 1'b0;

  typedef logic [SEL_W-1:0] sel_t;

  typedef struct packed {
    sel_t [NUM_REGS-1:0][1:0]   sel;
    logic [NUM_PINS-1:0]        pin_s1;
    logic [NUM_PINS-1:0]        pin_s2;
    logic [NUM_REGS-1:0][1:0]   route;
    logic [DATA_W-1:0]          rdata;
  } state_t;

  localparam state_t STATE_RESET = '{
    sel:    {(NUM_REGS * 2){SEL_RESET}},
    pin_s1: '0,
    pin_s2: '0,
    route:  {(NUM_REGS * 2){INACTIVE_LEVEL}},
    rdata:  32'h0000_0000
  };

endpackage : input_select_pkg

`default_nettype wire

// ===== verilog/remappable_input_select.sv
// Input-side pin routing: APB-programmed 6-bit selectors pick which
// remappable pin feeds each peripheral input.
// Assumes pins arrive asynchronously; lock and analog flags come from
// logic on the same clock.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module remappable_input_select
  import input_select_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  input  wire logic                 CE,
  // APB slave
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [ADDR_W-1:0]    PADDR,
  input  wire logic [DATA_W-1:0]    PWDATA,
  input  wire logic [STRB_W-1:0]    PSTRB,
  output logic                      PREADY,
  output logic                      PSLVERR,
  output logic      [DATA_W-1:0]    PRDATA,
  // Lock and pin configuration
  input  wire logic                 ROUTING_LOCK,
  input  wire logic [NUM_PINS-1:0]  ANALOG_SEL,
  // Remappable and input-only pins
  input  wire logic [NUM_PINS-1:0]  REMAPPABLE_PIN,
  // Routed peripheral inputs
  output logic                      TIMER4_EXT_CLOCK,
  output logic                      TIMER5_EXT_CLOCK,
  output logic                      CAPTURE_CH1,
  output logic                      CAPTURE_CH2,
  output logic                      CAPTURE_CH3,
  output logic                      CAPTURE_CH4,
  output logic                      CAPTURE_CH5,
  output logic                      CAPTURE_CH6,
  output logic                      CAPTURE_CH7,
  output logic                      CAPTURE_CH8,
  output logic                      CAPTURE_CH9,
  output logic                      COMPARE_FAULT_A,
  output logic                      COMPARE_FAULT_B,
  output logic                      SERIAL3_RECEIVE,
  output logic                      SERIAL1_RECEIVE,
  output logic                      SERIAL1_CLEAR_TO_SEND
);

  state_t              state_q;
  state_t              state_d;
  logic [IDX_W-1:0]    reg_idx;
  logic                addr_hit;
  logic                setup_phase;
  logic                access_phase;
  logic                write_ok;
  wire logic [NUM_REGS-1:0][1:0] picked;

  // Address decode: aligned words inside the register window only
  always_comb
  begin
    reg_idx  = PADDR[IDX_LSB +: IDX_W];
    addr_hit = 1'b0;
    case (PADDR)
      OFS_TIMER45,
      OFS_CAPTURE12,
      OFS_CAPTURE34,
      OFS_CAPTURE56,
      OFS_CAPTURE78,
      OFS_FAULT,
      OFS_CAPTURE9,
      OFS_SERIAL3,
      OFS_SERIAL1: addr_hit = 1'b1;
      default:     addr_hit = 1'b0;
    endcase
  end

  assign setup_phase  = PSEL && !PENABLE;
  assign access_phase = PSEL && PENABLE;

  assign write_ok = access_phase && PWRITE && addr_hit && !ROUTING_LOCK;

  always_comb
  begin
    int   r;
    r       = 0;
    state_d = state_q;

    // Two-flop pin synchroniser
    state_d.pin_s1 = REMAPPABLE_PIN;
    state_d.pin_s2 = state_q.pin_s1;

    // only implemented fields take write data, per byte lane
    if (write_ok)
    begin
      for (r = 0; r < NUM_REGS; r++)
      begin
        if (reg_idx == IDX_W'(r))
        begin
          if (IMPL_HI[r] && PSTRB[LANE_HI])
          begin
            state_d.sel[r][HALF_HI] = PWDATA[HI_LSB +: SEL_W];
          end
          // no low field in capture 9
          // no low field in serial 3
          if (IMPL_LO[r] && PSTRB[LANE_LO])
          begin
            state_d.sel[r][HALF_LO] = PWDATA[LO_LSB +: SEL_W];
          end
        end
      end
    end

    // Read data captured in the setup cycle; unimplemented bits zero
    if (setup_phase && !PWRITE)
    begin
      state_d.rdata = 32'h0000_0000;
      if (addr_hit)
      begin
        for (r = 0; r < NUM_REGS; r++)
        begin
          if (reg_idx == IDX_W'(r))
          begin
            if (IMPL_HI[r])
            begin
              state_d.rdata[HI_LSB +: SEL_W] = state_q.sel[r][HALF_HI];
            end
            if (IMPL_LO[r])
            begin
              state_d.rdata[LO_LSB +: SEL_W] = state_q.sel[r][HALF_LO];
            end
          end
        end
      end
    end

    // Routing flops take the level each field picks
    state_d.route = picked;
  end

  pin_pick #(.LIVE(IMPL_HI[IDX_TIMER45])) i_pick_timer5 (
    .sel          (state_q.sel[IDX_TIMER45][HALF_HI]),
    .pins         (state_q.pin_s2),
    .analog_flags (ANALOG_SEL),
    .level        (picked[IDX_TIMER45][HALF_HI])
  );
  pin_pick #(.LIVE(IMPL_LO[IDX_TIMER45])) i_pick_timer4 (
    .sel          (state_q.sel[IDX_TIMER45][HALF_LO]),
    .pins         (state_q.pin_s2),
    .analog_flags (ANALOG_SEL),
    .level        (picked[IDX_TIMER45][HALF_LO])
  );
  pin_pick #(.LIVE(IMPL_HI[IDX_CAPTURE12])) i_pick_capture2 (
    .sel          (state_q.sel[IDX_CAPTURE12][HALF_HI]),
    .pins         (state_q.pin_s2),
    .analog_flags (ANALOG_SEL),
    .level        (picked[IDX_CAPTURE12][HALF_HI])
  );
  pin_pick #(.LIVE(IMPL_LO[IDX_CAPTURE12])) i_pick_capture1 (
    .sel          (state_q.sel[IDX_CAPTURE12][HALF_LO]),
    .pins         (state_q.pin_s2),
    .analog_flags (ANALOG_SEL),
    .level        (picked[IDX_CAPTURE12][HALF_LO])
  );
  pin_pick #(.LIVE(IMPL_HI[IDX_CAPTURE34])) i_pick_capture4 (
    .sel          (state_q.sel[IDX_CAPTURE34][HALF_HI]),
    .pins         (state_q.pin_s2),
    .analog_flags (ANALOG_SEL),
    .level        (picked[IDX_CAPTURE34][HALF_HI])
  );
  pin_pick #(.LIVE(IMPL_LO[IDX_CAPTURE34])) i_pick_capture3 (
    .sel          (state_q.sel[IDX_CAPTURE34][HALF_LO]),
    .pins         (state_q.pin_s2),
    .analog_flags (ANALOG_SEL),
    .level        (picked[IDX_CAPTURE34][HALF_LO])
  );
  pin_pick #(.LIVE(IMPL_HI[IDX_CAPTURE56])) i_pick_capture6 (
    .sel          (state_q.sel[IDX_CAPTURE56][HALF_HI]),
    .pins         (state_q.pin_s2),
    .analog_flags (ANALOG_SEL),
    .level        (picked[IDX_CAPTURE56][HALF_HI])
  );
  pin_pick #(.LIVE(IMPL_LO[IDX_CAPTURE56])) i_pick_capture5 (
    .sel          (state_q.sel[IDX_CAPTURE56][HALF_LO]),
    .pins         (state_q.pin_s2),
    .analog_flags (ANALOG_SEL),
    .level        (picked[IDX_CAPTURE56][HALF_LO])
  );
  pin_pick #(.LIVE(IMPL_HI[IDX_CAPTURE78])) i_pick_capture8 (
    .sel          (state_q.sel[IDX_CAPTURE78][HALF_HI]),
    .pins         (state_q.pin_s2),
    .analog_flags (ANALOG_SEL),
    .level        (picked[IDX_CAPTURE78][HALF_HI])
  );
  pin_pick #(.LIVE(IMPL_LO[IDX_CAPTURE78])) i_pick_capture7 (
    .sel          (state_q.sel[IDX_CAPTURE78][HALF_LO]),
    .pins         (state_q.pin_s2),
    .analog_flags (ANALOG_SEL),
    .level        (picked[IDX_CAPTURE78][HALF_LO])
  );
  pin_pick #(.LIVE(IMPL_HI[IDX_FAULT])) i_pick_fault_b (
    .sel          (state_q.sel[IDX_FAULT][HALF_HI]),
    .pins         (state_q.pin_s2),
    .analog_flags (ANALOG_SEL),
    .level        (picked[IDX_FAULT][HALF_HI])
  );
  pin_pick #(.LIVE(IMPL_LO[IDX_FAULT])) i_pick_fault_a (
    .sel          (state_q.sel[IDX_FAULT][HALF_LO]),
    .pins         (state_q.pin_s2),
    .analog_flags (ANALOG_SEL),
    .level        (picked[IDX_FAULT][HALF_LO])
  );
  // capture 9 field, low half dead
  pin_pick #(.LIVE(IMPL_HI[IDX_CAPTURE9])) i_pick_capture9 (
    .sel          (state_q.sel[IDX_CAPTURE9][HALF_HI]),
    .pins         (state_q.pin_s2),
    .analog_flags (ANALOG_SEL),
    .level        (picked[IDX_CAPTURE9][HALF_HI])
  );
  pin_pick #(.LIVE(IMPL_LO[IDX_CAPTURE9])) i_pick_capture9_spare (
    .sel          (state_q.sel[IDX_CAPTURE9][HALF_LO]),
    .pins         (state_q.pin_s2),
    .analog_flags (ANALOG_SEL),
    .level        (picked[IDX_CAPTURE9][HALF_LO])
  );
  // serial 3 receive field, low half dead
  pin_pick #(.LIVE(IMPL_HI[IDX_SERIAL3])) i_pick_serial3_receive (
    .sel          (state_q.sel[IDX_SERIAL3][HALF_HI]),
    .pins         (state_q.pin_s2),
    .analog_flags (ANALOG_SEL),
    .level        (picked[IDX_SERIAL3][HALF_HI])
  );
  pin_pick #(.LIVE(IMPL_LO[IDX_SERIAL3])) i_pick_serial3_spare (
    .sel          (state_q.sel[IDX_SERIAL3][HALF_LO]),
    .pins         (state_q.pin_s2),
    .analog_flags (ANALOG_SEL),
    .level        (picked[IDX_SERIAL3][HALF_LO])
  );
  pin_pick #(.LIVE(IMPL_HI[IDX_SERIAL1])) i_pick_serial1_clear_to_send (
    .sel          (state_q.sel[IDX_SERIAL1][HALF_HI]),
    .pins         (state_q.pin_s2),
    .analog_flags (ANALOG_SEL),
    .level        (picked[IDX_SERIAL1][HALF_HI])
  );
  pin_pick #(.LIVE(IMPL_LO[IDX_SERIAL1])) i_pick_serial1_receive (
    .sel          (state_q.sel[IDX_SERIAL1][HALF_LO]),
    .pins         (state_q.pin_s2),
    .analog_flags (ANALOG_SEL),
    .level        (picked[IDX_SERIAL1][HALF_LO])
  );

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      state_q <= STATE_RESET;
    end
    else if (CE)
    begin
      state_q <= state_d;
    end
  end

  // Zero-wait APB answer; unmapped addresses raise an error
  assign PREADY  = access_phase;
  assign PSLVERR = access_phase && !addr_hit;
  assign PRDATA  = state_q.rdata;

  // outputs only feed peripherals; no enable or pin control leaves here
  assign TIMER5_EXT_CLOCK      = state_q.route[IDX_TIMER45][HALF_HI];
  assign TIMER4_EXT_CLOCK      = state_q.route[IDX_TIMER45][HALF_LO];
  assign CAPTURE_CH2           = state_q.route[IDX_CAPTURE12][HALF_HI];
  assign CAPTURE_CH1           = state_q.route[IDX_CAPTURE12][HALF_LO];
  assign CAPTURE_CH4           = state_q.route[IDX_CAPTURE34][HALF_HI];
  assign CAPTURE_CH3           = state_q.route[IDX_CAPTURE34][HALF_LO];
  assign CAPTURE_CH6           = state_q.route[IDX_CAPTURE56][HALF_HI];
  assign CAPTURE_CH5           = state_q.route[IDX_CAPTURE56][HALF_LO];
  assign CAPTURE_CH8           = state_q.route[IDX_CAPTURE78][HALF_HI];
  assign CAPTURE_CH7           = state_q.route[IDX_CAPTURE78][HALF_LO];
  assign COMPARE_FAULT_B       = state_q.route[IDX_FAULT][HALF_HI];
  assign COMPARE_FAULT_A       = state_q.route[IDX_FAULT][HALF_LO];
  assign CAPTURE_CH9           = state_q.route[IDX_CAPTURE9][HALF_HI];
  assign SERIAL3_RECEIVE       = state_q.route[IDX_SERIAL3][HALF_HI];
  assign SERIAL1_CLEAR_TO_SEND = state_q.route[IDX_SERIAL1][HALF_HI];
  assign SERIAL1_RECEIVE       = state_q.route[IDX_SERIAL1][HALF_LO];

endmodule : remappable_input_select

// One selector field: the level of the pin its value names, or inactive.
module pin_pick
  import input_select_pkg::*;
#(
  parameter bit LIVE = 1'b1
)
(
  // Field value
  input  wire logic [SEL_W-1:0]    sel,
  // Synchronised pin levels and analog flags
  input  wire logic [NUM_PINS-1:0] pins,
  input  wire logic [NUM_PINS-1:0] analog_flags,
  // Picked level
  output logic                     level
);

  always_comb
  begin
    // no such pin, or no field behind this input
    if (!LIVE || (int'(sel) >= NUM_PINS))
    begin
      level = INACTIVE_LEVEL;
    end
    else if (analog_flags[sel])
    begin
      level = INACTIVE_LEVEL;
    end
    else
    begin
      level = pins[sel];
    end
  end

endmodule : pin_pick

`default_nettype wire
